// ==== tb/pcec_queue_model.sv ====
// Two-entry CPU service request queue that faces the error checker
`timescale 1ns/1ps
module pcec_queue_model (
   input  wire logic ref_clk_i,
   input  wire logic nrst_i,
   input  wire logic slow_i,
   input  wire logic srv_req_i,
   output logic      queue_full_o
);
   logic [1:0] fill;
   assign queue_full_o = fill == 2'h2;
   // A slow CPU acknowledges nothing, so the queue fills up
   always @(posedge ref_clk_i or negedge nrst_i)
      if (!nrst_i)
         fill <= 2'h0;
      else
         fill <= fill + 2'(srv_req_i) - 2'(!slow_i && fill != 2'h0);
endmodule

// ==== tb/pcec_top_sva.sv ====
// Port assertions for the coprocessor error checker
`timescale 1ns/1ps
module pcec_top_sva (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic partition_enable_i,
   input wire logic [7:0] partition_size_i,
   input wire logic chan_wdog_enable_i,
   input wire logic [7:0] chan_wdog_threshold_i,
   input wire logic chan_start_i,
   input wire logic [7:0] chan_num_i,
   input wire logic irq_i,
   input wire logic parameter_ram_write_i,
   input wire logic [13:0] parameter_ram_addr_i,
   input wire logic fetch_i,
   input wire logic exec_i,
   input wire logic opcode_legal_i,
   input wire logic queue_full_i,
   input wire logic abort_o,
   input wire logic srv_req_o,
   input wire logic err_valid_o,
   input wire logic [7:0] err_chan_o,
   input wire logic [7:0] fetch_count_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   a_bad_opcode: assert property (ce_i && exec_i && !opcode_legal_i |-> abort_o)
      else $error("illegal opcode not aborted");
   a_status_kept: assert property (abort_o |=> err_valid_o && err_chan_o == $past(chan_num_i))
      else $error("status not recorded");
   a_csa_write: assert property (ce_i && partition_enable_i && parameter_ram_write_i
      && parameter_ram_addr_i < {partition_size_i, 3'h0} |-> abort_o) else $error("save area write passed");
   a_csa_zero: assert property (ce_i && partition_enable_i && partition_size_i == 8'h00 && irq_i |-> abort_o)
      else $error("empty save area passed");
   a_wdog_fire: assert property (ce_i && chan_wdog_enable_i && chan_wdog_threshold_i != 8'h00
      && fetch_count_o >= chan_wdog_threshold_i && !chan_start_i |-> abort_o) else $error("watchdog silent");
   a_count_clear: assert property (ce_i && chan_start_i && !fetch_i |=> fetch_count_o == 8'h00)
      else $error("count not cleared");
   a_count_step: assert property (ce_i && fetch_i && !chan_start_i && fetch_count_o != 8'hff
      |=> fetch_count_o == $past(fetch_count_o) + 8'h01) else $error("count not stepped");
   a_srv_issue: assert property (abort_o ##1 (ce_i && !queue_full_i) |=> srv_req_o)
      else $error("no service request");
endmodule
bind pcec_top pcec_top_sva u_sva (.*);

// ==== tb/testbench.sv ====
// Self-checking bench for the coprocessor error checker
`timescale 1ns/1ps
module testbench;
   logic ref_clk_i = 0, nrst_i = 0, ce_i = 1, partition_enable_i = 0, chan_wdog_enable_i = 0, chan_start_i = 0;
   logic irq_i = 0, parameter_ram_write_i = 0, fetch_i = 0, exec_i = 0, opcode_legal_i = 1, rel_jump_i = 0, pc_incr_i = 0;
   logic status_clear_i = 0, slow = 0;
   logic pe, pw;
   logic [7:0] thr, ps;
   logic [13:0] pa;
   logic [7:0] partition_size_i = 0, chan_wdog_threshold_i = 0, error_request_priority_i = 0, chan_num_i = 0;
   logic [13:0] ctx_load_addr_i = 0, parameter_ram_addr_i = 0;
   logic [15:0] opcode_i = 0, exec_pc_i = 0, next_pc_i = 0, jump_offset_i = 0;
   wire abort_o, stall_o, srv_req_o, err_valid_o, queue_full_i;
   wire [7:0] srv_prio_o, err_chan_o, fetch_count_o;
   wire [2:0] err_cause_o;
   wire [15:0] err_addr_o;
   int error_cnt = 0, num_checks = 0, n;
   always #25 ref_clk_i = ~ref_clk_i;
   pcec_top u_dut (.*);
   pcec_queue_model u_q (.ref_clk_i, .nrst_i, .slow_i(slow), .srv_req_i(srv_req_o), .queue_full_o(queue_full_i));
   task chk(input logic [15:0] g, e);
      num_checks++;
      error_cnt += int'(g !== e);
      if (g !== e) $display("wrong value at %0t: got %h want %h", $time, g, e);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Expected partition cause: the save area spans size times eight words
   function automatic logic [2:0] part_exp(input logic en, w, input logic [7:0] sz, input logic [13:0] a);
      return (en && (w ? a < sz * 8 : (a >= sz * 8 || sz == 0))) ? 3'h1 : 3'h0;
   endfunction
   // Lets the pulses be taken, checks status, clears it and checks the request
   task hit(input logic [2:0] c);
      #1 chk(abort_o, c != 0);
      @(posedge ref_clk_i);
      {irq_i, parameter_ram_write_i, exec_i, rel_jump_i, pc_incr_i, chan_wdog_enable_i} <= '0;
      opcode_legal_i <= 1;
      #1 chk(err_cause_o, c);
      chk(err_valid_o, c != 0);
      @(posedge ref_clk_i);
      status_clear_i <= 1;
      #1 chk(srv_req_o, c != 0);
      @(posedge ref_clk_i);
      status_clear_i <= 0;
   endtask
   task part(input logic en, w, input logic [7:0] sz, input logic [13:0] a, input logic [2:0] c);
      partition_enable_i <= en;
      partition_size_i <= sz;
      parameter_ram_write_i <= w;
      irq_i <= !w;
      parameter_ram_addr_i <= a;
      ctx_load_addr_i <= a;
      hit(c);
   endtask
   initial
   begin
      #1000000 error_cnt++;
      $display("wrong value at %0t: run timed out", $time);
      print_verdict;
   end
   initial
   begin
      n = $urandom(8295);
      repeat (2) @(posedge ref_clk_i);
      nrst_i <= 1;
      #1 chk(err_valid_o, 0);
      @(posedge ref_clk_i);
      repeat (4)
      begin
         exec_pc_i <= 16'($urandom_range(4095));
         chan_num_i <= 8'($urandom);
         error_request_priority_i <= 8'($urandom);
         opcode_i <= 16'($urandom);
         exec_i <= 1;
         opcode_legal_i <= 0;
         hit(3'h3);
         chk(err_addr_o, exec_pc_i);
         chk(err_chan_o, chan_num_i);
         chk(srv_prio_o, error_request_priority_i);
      end
      $display("opcode test done");
      exec_i <= 1;
      exec_pc_i <= 16'h1000;
      hit(3'h4);
      pc_incr_i <= 1;
      exec_pc_i <= 16'hffff;
      hit(3'h4);
      rel_jump_i <= 1;
      next_pc_i <= 16'hff00;
      jump_offset_i <= 16'h0200;
      hit(3'h4);
      $display("address test done");
      part(0, 1, 8'h00, 14'h0000, 3'h0);
      part(1, 1, 8'h02, 14'h000f, 3'h1);
      part(1, 1, 8'h02, 14'h0010, 3'h0);
      part(1, 0, 8'h02, 14'h0014, 3'h1);
      part(1, 0, 8'h02, 14'h0008, 3'h0);
      part(1, 0, 8'h00, 14'h0000, 3'h1);
      part(0, 0, 8'h00, 14'h0000, 3'h0);
      repeat (8)
      begin
         {pe, pw, ps} = 10'($urandom);
         pa = 14'($urandom_range(2047));
         part(pe, pw, ps, pa, part_exp(pe, pw, ps, pa));
      end
      $display("partition test done");
      thr = 8'(2 + $urandom_range(7));
      chan_wdog_threshold_i <= thr;
      chan_wdog_enable_i <= 1;
      fetch_i <= 1;
      repeat (thr - 1) @(posedge ref_clk_i);
      #1 chk(abort_o, 0);
      chk(err_valid_o, 0);
      @(posedge ref_clk_i);
      fetch_i <= 0;
      #1 chk(fetch_count_o, chan_wdog_threshold_i);
      chk(err_valid_o, 0);
      hit(3'h2);
      chan_start_i <= 1;
      @(posedge ref_clk_i);
      chan_start_i <= 0;
      #1 chk(fetch_count_o, 0);
      @(posedge ref_clk_i);
      chan_wdog_enable_i <= 1;
      chan_wdog_threshold_i <= 8'h00;
      irq_i <= 1;
      hit(3'h2);
      $display("watchdog test done");
      {ce_i, exec_i, opcode_legal_i, fetch_i} <= 4'b0101;
      #1 chk(abort_o, 0);
      @(posedge ref_clk_i);
      {ce_i, exec_i, opcode_legal_i, fetch_i} <= 4'b1010;
      #1 chk(err_valid_o, 0);
      chk(fetch_count_o, 0);
      @(posedge ref_clk_i);
      $display("clock enable test done");
      slow <= 1;
      repeat (3)
      begin
         exec_i <= 1;
         opcode_legal_i <= 0;
         @(posedge ref_clk_i);
         exec_i <= 0;
         opcode_legal_i <= 1;
         repeat (3) @(posedge ref_clk_i);
      end
      #1 chk(stall_o, 1);
      slow <= 0;
      for (n = 0; n < 9 && srv_req_o !== 1; n++) @(negedge ref_clk_i);
      chk(n < 9, 1);
      $display("queue test done");
      print_verdict;
   end
endmodule

// ==== verilog/pcec_decode.v ====
// Opcode legality and instruction address checks
`timescale 1ns/1ps
`include "pcec_map.vh"
module pcec_decode (
   input  wire                   exec_i,
   input  wire [`PCEC_PC_W-1:0]  opcode_i,
   input  wire [`PCEC_PC_W-1:0]  exec_pc_i,
   input  wire                   rel_jump_i,
   input  wire [`PCEC_PC_W-1:0]  next_pc_i,
   input  wire [`PCEC_PC_W-1:0]  jump_offset_i,
   input  wire                   pc_incr_i,
   input  wire                   opcode_legal_i,
   output wire                   bad_opcode_o,
   output wire                   bad_addr_o
);
   wire [`PCEC_PC_W:0] jump_sum;
   wire [`PCEC_PC_W:0] incr_sum;
   wire [`PCEC_PC_W:0] exec_ext;
   assign jump_sum = {1'b0, next_pc_i} + {1'b0, jump_offset_i};
   assign incr_sum = {1'b0, exec_pc_i} + {{`PCEC_PC_W{1'b0}}, 1'b1};
   assign exec_ext = {1'b0, exec_pc_i};
   assign bad_opcode_o = exec_i && !opcode_legal_i;
   // Signed offsets: a carry out flags overflow for forward jumps, a missing carry flags underflow for backward jumps
   assign bad_addr_o = (exec_i && exec_ext >= `PCEC_CODE_MEMORY_SIZE)
                     || (rel_jump_i && !jump_offset_i[`PCEC_PC_W-1] && jump_sum[`PCEC_PC_W])
                     || (rel_jump_i && jump_offset_i[`PCEC_PC_W-1] && !jump_sum[`PCEC_PC_W])
                     || (pc_incr_i && incr_sum[`PCEC_PC_W]);
endmodule

// ==== verilog/pcec_map.vh ====
// Constants for the coprocessor error checker
`ifndef PCEC_MAP_VH
`define PCEC_MAP_VH
`define PCEC_PC_W          16
`define PCEC_PARAMETER_RAM_AW       14
`define PCEC_CHAN_W        8
`define PCEC_PPS_W         8
`define PCEC_CWT_W         8
`define PCEC_PRIO_W        8
`define PCEC_CAUSE_W       3
`define PCEC_CAUSE_NONE    3'h0
`define PCEC_CAUSE_PART    3'h1
`define PCEC_CAUSE_WDOG    3'h2
`define PCEC_CAUSE_OPCODE  3'h3
`define PCEC_CAUSE_IADDR   3'h4
`define PCEC_CSA_SHIFT     3
`define PCEC_CODE_MEMORY_SIZE     17'h0_1000
`define PCEC_ZERO8         8'h00
`define PCEC_ONE8          8'h01
`define PCEC_ZERO16        16'h0000
`endif

// ==== verilog/pcec_top.v ====
// Coprocessor error checker top level
// Operation
// - Any error aborts the channel and records cause, address, channel.
// - Partition checks only when partition_enable set; size from partition_size.
// - Partition disabled: all parameter RAM writes allowed without error.
// - Partition enabled: writes into the context save area raise an error.
// - Partition enabled: context load outside save area on request errors.
// - Partition enabled with size zero errors on every interrupt request.
// - Count instruction words fetched since the channel started.
// - Watchdog enabled and count reaching threshold raises an error.
// - One watchdog threshold shared by all channels.
// - A 32-bit instruction counts twice, once per code memory read.
// - Watchdog enabled with threshold zero errors on every request.
// - Executing an illegal opcode raises an invalid opcode error.
// - Executing beyond implemented code memory raises an address error.
// - Program counter overflow from jump or increment raises address error.
// - An error posts a CPU service request with the error priority, unless a request already waits on a full queue.
`timescale 1ns/1ps
`include "pcec_map.vh"
module pcec_top (
   input  wire                      ref_clk_i,
   input  wire                      nrst_i,
   input  wire                      ce_i,
   input  wire                      partition_enable_i,
   input  wire [`PCEC_PPS_W-1:0]    partition_size_i,
   input  wire                      chan_wdog_enable_i,
   input  wire [`PCEC_CWT_W-1:0]    chan_wdog_threshold_i,
   input  wire [`PCEC_PRIO_W-1:0]   error_request_priority_i,
   input  wire                      chan_start_i,
   input  wire [`PCEC_CHAN_W-1:0]   chan_num_i,
   input  wire                      irq_i,
   input  wire [`PCEC_PARAMETER_RAM_AW-1:0]  ctx_load_addr_i,
   input  wire                      parameter_ram_write_i,
   input  wire [`PCEC_PARAMETER_RAM_AW-1:0]  parameter_ram_addr_i,
   input  wire                      fetch_i,
   input  wire                      exec_i,
   input  wire [`PCEC_PC_W-1:0]     opcode_i,
   input  wire                      opcode_legal_i,
   input  wire [`PCEC_PC_W-1:0]     exec_pc_i,
   input  wire                      rel_jump_i,
   input  wire [`PCEC_PC_W-1:0]     next_pc_i,
   input  wire [`PCEC_PC_W-1:0]     jump_offset_i,
   input  wire                      pc_incr_i,
   input  wire                      queue_full_i,
   input  wire                      status_clear_i,
   output wire                      abort_o,
   output wire                      stall_o,
   output reg                       srv_req_o,
   output reg  [`PCEC_PRIO_W-1:0]   srv_prio_o,
   output reg  [`PCEC_CAUSE_W-1:0]  err_cause_o,
   output reg  [`PCEC_PC_W-1:0]     err_addr_o,
   output reg  [`PCEC_CHAN_W-1:0]   err_chan_o,
   output reg                       err_valid_o,
   output wire [`PCEC_CWT_W-1:0]    fetch_count_o
);
   // Context save area top, in words
   function [`PCEC_PARAMETER_RAM_AW:0] csa_limit;
      input [`PCEC_PPS_W-1:0] size;
      begin
         csa_limit = {{(`PCEC_PARAMETER_RAM_AW+1-`PCEC_PPS_W){1'b0}}, size} << `PCEC_CSA_SHIFT;
      end
   endfunction

   function in_csa;
      input [`PCEC_PARAMETER_RAM_AW-1:0] addr;
      input [`PCEC_PPS_W-1:0]   size;
      begin
         in_csa = ({1'b0, addr} < csa_limit(size));
      end
   endfunction

   wire wdog_expired;
   wire bad_opcode;
   wire bad_addr;
   wire part_err;
   wire wdog_err;
   wire any_err;
   reg  pending;
   reg  [`PCEC_PRIO_W-1:0] pend_prio;
   reg  [`PCEC_CAUSE_W-1:0] cause;

   pcec_wdog u_wdog (
      .ref_clk_i   (ref_clk_i),
      .nrst_i      (nrst_i),
      .ce_i        (ce_i),
      .chan_start_i(chan_start_i),
      .fetch_i     (fetch_i),
      .enable_i    (chan_wdog_enable_i),
      .threshold_i (chan_wdog_threshold_i),
      .expired_o   (wdog_expired),
      .count_o     (fetch_count_o)
   );

   pcec_decode u_decode (
      .exec_i        (exec_i),
      .opcode_i      (opcode_i),
      .exec_pc_i     (exec_pc_i),
      .rel_jump_i    (rel_jump_i),
      .next_pc_i     (next_pc_i),
      .jump_offset_i (jump_offset_i),
      .pc_incr_i     (pc_incr_i),
      .opcode_legal_i(opcode_legal_i),
      .bad_opcode_o  (bad_opcode),
      .bad_addr_o    (bad_addr)
   );

   // Partitioning gated by enable; disabled means no partition error at all
   assign part_err = partition_enable_i && (
                        (parameter_ram_write_i && in_csa(parameter_ram_addr_i, partition_size_i))
                     || (irq_i && !in_csa(ctx_load_addr_i, partition_size_i))
                     || (irq_i && partition_size_i == `PCEC_ZERO8));

   assign wdog_err = wdog_expired
                  || (irq_i && chan_wdog_enable_i && chan_wdog_threshold_i == `PCEC_ZERO8);

   assign any_err = part_err || wdog_err || bad_opcode || bad_addr;

   // Fixed priority of cause reporting
   always @*
   begin
      cause = `PCEC_CAUSE_NONE;
      if (part_err)
         cause = `PCEC_CAUSE_PART;
      else if (wdog_err)
         cause = `PCEC_CAUSE_WDOG;
      else if (bad_opcode)
         cause = `PCEC_CAUSE_OPCODE;
      else if (bad_addr)
         cause = `PCEC_CAUSE_IADDR;
   end

   assign abort_o = ce_i && any_err;
   // Core must stall while an error request waits for a free queue entry
   assign stall_o = pending && queue_full_i;

   always @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         err_cause_o <= `PCEC_CAUSE_NONE;
         err_addr_o  <= `PCEC_ZERO16;
         err_chan_o  <= `PCEC_ZERO8;
         err_valid_o <= 1'b0;
      end
      else if (ce_i)
      begin
         if (any_err)
         begin
            err_cause_o <= cause;
            err_addr_o  <= exec_pc_i;
            err_chan_o  <= chan_num_i;
            err_valid_o <= 1'b1;
         end
         else if (status_clear_i)
         begin
            err_cause_o <= `PCEC_CAUSE_NONE;
            err_valid_o <= 1'b0;
         end
      end
   end

   // Service request toward CPU queue, held back while the queue is full
   always @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pending    <= 1'b0;
         pend_prio  <= `PCEC_ZERO8;
         srv_req_o  <= 1'b0;
         srv_prio_o <= `PCEC_ZERO8;
      end
      else if (ce_i)
      begin
         srv_req_o <= 1'b0;
         if (pending && !queue_full_i)
         begin
            srv_req_o  <= 1'b1;
            srv_prio_o <= pend_prio;
            pending    <= any_err;
            pend_prio  <= error_request_priority_i;
         end
         else if (any_err && !pending)
         begin
            pending   <= 1'b1;
            pend_prio <= error_request_priority_i;
         end
      end
   end
endmodule

// ==== verilog/pcec_wdog.v ====
// Channel watchdog fetch counter
`timescale 1ns/1ps
`include "pcec_map.vh"
module pcec_wdog (
   input  wire                    ref_clk_i,
   input  wire                    nrst_i,
   input  wire                    ce_i,
   input  wire                    chan_start_i,
   input  wire                    fetch_i,
   input  wire                    enable_i,
   input  wire [`PCEC_CWT_W-1:0]  threshold_i,
   output wire                    expired_o,
   output reg  [`PCEC_CWT_W-1:0]  count_o
);
   reg [`PCEC_CWT_W-1:0] next_count;
   always @*
   begin
      next_count = count_o;
      if (chan_start_i)
         next_count = `PCEC_ZERO8;
      else if (fetch_i && count_o != {`PCEC_CWT_W{1'b1}})
         next_count = count_o + `PCEC_ONE8;
   end
   always @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         count_o <= `PCEC_ZERO8;
      else if (ce_i)
         count_o <= next_count;
   end
   // One shared threshold for every channel
   assign expired_o = enable_i && !chan_start_i && (count_o >= threshold_i)
                      && (threshold_i != `PCEC_ZERO8);
endmodule
